// ---- rtl/usmr_top.v ----
/*
  Serial port block: register file, synchronous master and slave receive
  engine with two-entry buffer, overrun handling and interrupt request.
  Assumes a one-cycle register port master on clk_sys and an external
  serial peripheral on the clock and data pins, which are asynchronous.
*/
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`include "usmr_consts.vh"
module usmr_top
(
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst_n,
  // Register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata_r,
  // Serial clock pin
  input  wire       sck_i,
  output reg        sck_o_r,
  output reg        sck_oe_r,
  // Serial data pin
  input  wire       dat_i,
  output reg        dat_o_r,
  output reg        dat_oe_r,
  // Status to the rest of the chip
  output reg        irq_r,
  output reg        tx_enable_r
);
  // ========================================================================
  // Reset release
  reg        rst_m_r;
  reg        rst_s_r;
  wire       rst_l_n;

  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end
    else
    begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end

  assign rst_l_n = rst_s_r;

  // ========================================================================
  // Pin synchronisers
  reg        sck_m_r;
  reg        sck_s_r;
  reg        sck_d_r;
  reg        dat_m_r;
  reg        dat_s_r;

  always @(posedge clk_sys or negedge rst_l_n)
    if (!rst_l_n)
    begin
      sck_m_r <= 1'b0;
      sck_s_r <= 1'b0;
      sck_d_r <= 1'b0;
      dat_m_r <= 1'b0;
      dat_s_r <= 1'b0;
    end
    else
    begin
      sck_m_r <= sck_i;
      sck_s_r <= sck_m_r;
      sck_d_r <= sck_s_r;
      dat_m_r <= dat_i;
      dat_s_r <= dat_m_r;
    end

  // ========================================================================
  // Register state
  reg  [7:0] intctl_r;
  reg  [7:0] irqflg_r;
  reg  [7:0] irqen_r;
  reg  [7:0] baud_r;
  reg        serial_port_enable_r;
  reg        rx9_r;
  reg        single_receive_enable_r;
  reg        continuous_receive_enable_r;
  reg        overrun_error_bit_r;
  reg        clock_source_select_r;
  reg        tx9_r;
  reg        transmit_enable_bit_r;
  reg        sync_r;
  reg        high_speed_select_r;
  reg        transmit_ninth_bit_r;

  // Receive engine state
  reg  [8:0] shreg_r;
  reg  [3:0] bitcnt_r;
  reg        sck_r;

  wire       wr_rx;
  wire       pop;
  wire       rx_en;
  wire       m_run;
  wire       s_run;
  wire       tick;
  wire       samp;
  wire       done;
  wire [3:0] last_bit;
  wire [8:0] shift_nxt;
  wire [8:0] word;
  wire       push;
  wire [8:0] head;
  wire       empty;
  wire       full;
  wire [7:0] prescale;
  reg  [7:0] rd_val;

  assign wr_rx = reg_wr && (reg_addr == `USMR_A_RXSTAT);
  assign pop   = reg_rd && (reg_addr == `USMR_A_RXDATA);

  // ========================================================================
  // Receive control
  assign rx_en    = single_receive_enable_r | continuous_receive_enable_r;
  assign m_run    = serial_port_enable_r & sync_r & clock_source_select_r & rx_en;
  assign s_run    = serial_port_enable_r & sync_r & ~clock_source_select_r & rx_en;
  // Async receive framing lives elsewhere; here async leaves the engine idle
  assign prescale = sync_r ? `USMR_PRE_SYNC :
                    (high_speed_select_r ? `USMR_PRE_AHIGH : `USMR_PRE_ALOW);
  // Sample when the driven clock falls, or on a synced external falling edge
  assign samp      = (m_run & tick & sck_r) | (s_run & sck_d_r & ~sck_s_r);
  assign last_bit  = rx9_r ? 4'h8 : 4'h7;
  assign done      = samp && (bitcnt_r == last_bit);
  assign shift_nxt = {dat_s_r, shreg_r[8:1]};
  // Eight-bit words sit in the upper bits after eight LSB-first shifts
  assign word      = rx9_r ? shift_nxt : {1'b0, shift_nxt[8:1]};
  assign push      = done & ~full & ~overrun_error_bit_r;

  usmr_baud u_baud
  (
    .clk_sys  (clk_sys),
    .rst_n    (rst_l_n),
    .run      (m_run),
    .divisor  (baud_r),
    .prescale (prescale),
    .tick_r   (tick)
  );

  usmr_fifo u_fifo
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_l_n),
    .push    (push),
    .wdat    (word),
    .pop     (pop),
    .head    (head),
    .empty   (empty),
    .full    (full)
  );

  // ========================================================================
  // Shift engine
  always @(posedge clk_sys or negedge rst_l_n)
    if (!rst_l_n)
    begin
      shreg_r  <= 9'h000;
      bitcnt_r <= 4'h0;
      sck_r    <= 1'b0;
    end
    else if (!(m_run | s_run))
    begin
      // Dropping the enable aborts a partial word
      bitcnt_r <= 4'h0;
      sck_r    <= 1'b0;
    end
    else
    begin
      if (m_run && tick)
        sck_r <= ~sck_r;
      if (samp)
      begin
        shreg_r  <= shift_nxt;
        bitcnt_r <= done ? 4'h0 : bitcnt_r + 4'h1;
      end
    end

  // ========================================================================
  // Receive status and control
  always @(posedge clk_sys or negedge rst_l_n)
    if (!rst_l_n)
    begin
      serial_port_enable_r <= 1'b0;
      rx9_r  <= 1'b0;
      single_receive_enable_r <= 1'b0;
      continuous_receive_enable_r <= 1'b0;
      overrun_error_bit_r <= 1'b0;
    end
    else
    begin
      if (wr_rx)
      begin
        serial_port_enable_r <= reg_wdata[`USMR_B_PORT_EN];
        rx9_r  <= reg_wdata[`USMR_B_RX_NINE];
        continuous_receive_enable_r <= reg_wdata[`USMR_B_RX_CONT];
      end
      // Single enable drops itself after one word unless continuous governs
      if (wr_rx)
        single_receive_enable_r <= reg_wdata[`USMR_B_RX_SINGLE];
      else if (done && !continuous_receive_enable_r)
        single_receive_enable_r <= 1'b0;
      // Set wins; clearing continuous enable is the only software clear
      if (done && full)
        overrun_error_bit_r <= 1'b1;
      else if (wr_rx && !reg_wdata[`USMR_B_RX_CONT])
        overrun_error_bit_r <= 1'b0;
    end

  // ========================================================================
  // Other registers
  always @(posedge clk_sys or negedge rst_l_n)
    if (!rst_l_n)
    begin
      intctl_r <= `USMR_RST_BYTE;
      irqflg_r <= `USMR_RST_BYTE;
      irqen_r  <= `USMR_RST_BYTE;
      baud_r   <= `USMR_RST_BYTE;
      clock_source_select_r   <= 1'b0;
      tx9_r    <= 1'b0;
      transmit_enable_bit_r   <= 1'b0;
      sync_r   <= 1'b0;
      high_speed_select_r   <= 1'b0;
      transmit_ninth_bit_r   <= 1'b0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `USMR_A_INTCTL: intctl_r <= reg_wdata;
        `USMR_A_IRQFLG: irqflg_r <= reg_wdata;
        `USMR_A_IRQEN:  irqen_r  <= reg_wdata;
        `USMR_A_BAUD:   baud_r   <= reg_wdata;
        `USMR_A_TXSTAT:
        begin
          clock_source_select_r <= reg_wdata[`USMR_B_CLK_SRC];
          tx9_r  <= reg_wdata[`USMR_B_TX_NINE];
          transmit_enable_bit_r <= reg_wdata[`USMR_B_TX_EN];
          sync_r <= reg_wdata[`USMR_B_SYNC];
          high_speed_select_r <= reg_wdata[`USMR_B_HIGH_SPEED];
          transmit_ninth_bit_r <= reg_wdata[`USMR_B_TX_NINTH];
        end
        default:
        begin
          intctl_r <= intctl_r;
        end
      endcase
    end

  // ========================================================================
  // Read mux
  always @*
  begin
    rd_val = 8'h00;
    case (reg_addr)
      `USMR_A_INTCTL: rd_val = intctl_r;
      // Receive complete is the buffer's own state, never a stored bit
      `USMR_A_IRQFLG: rd_val = {irqflg_r[7:6], ~empty, irqflg_r[4:0]};
      `USMR_A_IRQEN:  rd_val = irqen_r;
      `USMR_A_BAUD:   rd_val = baud_r;
      // Ninth bit shows the head entry, so read this before the data
      `USMR_A_RXSTAT: rd_val = {serial_port_enable_r, rx9_r, single_receive_enable_r, continuous_receive_enable_r, 1'b0, 1'b0, overrun_error_bit_r,
                                head[8] & ~empty};
      `USMR_A_RXDATA: rd_val = empty ? 8'h00 : head[7:0];
      // No transmitter is built, so the shifter always reads empty
      `USMR_A_TXSTAT: rd_val = {clock_source_select_r, tx9_r, transmit_enable_bit_r, sync_r, 1'b0, high_speed_select_r, 1'b1,
                                transmit_ninth_bit_r};
      default:        rd_val = 8'h00;
    endcase
  end

  // ========================================================================
  // Registered outputs
  always @(posedge clk_sys or negedge rst_l_n)
    if (!rst_l_n)
    begin
      reg_rdata_r <= 8'h00;
      sck_o_r     <= 1'b0;
      sck_oe_r    <= 1'b0;
      dat_o_r     <= 1'b0;
      dat_oe_r    <= 1'b0;
      irq_r       <= 1'b0;
      tx_enable_r <= 1'b0;
    end
    else
    begin
      reg_rdata_r <= reg_rd ? rd_val : 8'h00;
      sck_o_r     <= sck_r;
      sck_oe_r    <= serial_port_enable_r & sync_r & clock_source_select_r;
      // Receive only: the data pin is never driven here
      dat_o_r     <= 1'b0;
      dat_oe_r    <= 1'b0;
      irq_r       <= ~empty & irqen_r[`USMR_B_RX_DONE_IE] & intctl_r[`USMR_B_PERIPH_IE]
                     & intctl_r[`USMR_B_GLOB_IE];
      tx_enable_r <= transmit_enable_bit_r & ~(sync_r & rx_en);
    end
endmodule

// ---- common/usmr_consts.vh ----
/*
  Constants of the synchronous master receive serial block: register
  offsets, field positions, reset values and baud prescale counts.
  Assumes it is included by bare name from the rtl files.
*/
//
// Notes on behaviour
// - Block offers asynchronous, synchronous master and synchronous slave modes; here asynchronous mode leaves the receive engine idle.
// - Clock source bit picks master (own clock) or slave in synchronous mode.
// - Transmit enable bit enables sending; a receive enable overrides it when synchronous.
// - Mode select bit picks synchronous at one, asynchronous at zero.
// - High speed bit picks baud range in asynchronous mode only.
// - Shifter empty status reads one while transmit shifter empty, one after reset.
// - Lowest transmit control bit holds the ninth transmit bit.
// - Setting single or continuous receive enable starts synchronous reception.
// - Master reception samples the data line at each falling serial clock edge.
// - Single enable takes one word; continuous runs until cleared and wins.
// - Finished word moves to buffer if room, then receive complete flag sets.
// - Receive interrupt enable gates the flag onto the interrupt request.
// - Receive complete flag is read-only and clears when buffer is empty.
// - Receive buffer is a two-entry FIFO; two reads empty it.
// - Word finishing with full buffer sets overrun and is dropped.
// - Overrun blocks transfers; clearing continuous enable clears overrun.
// - Ninth bit is buffered per word; read status before data.
`ifndef USMR_CONSTS_VH
`define USMR_CONSTS_VH

// ==========================================================================
// Register offsets
`define USMR_A_INTCTL   8'h0b
`define USMR_A_IRQFLG   8'h0c
`define USMR_A_RXSTAT   8'h18
`define USMR_A_RXDATA   8'h1a
`define USMR_A_IRQEN    8'h8c
`define USMR_A_TXSTAT   8'h98
`define USMR_A_BAUD     8'h99

// ==========================================================================
// Field positions
`define USMR_B_GLOB_IE     7
`define USMR_B_PERIPH_IE   6
`define USMR_B_RX_DONE     5
`define USMR_B_RX_DONE_IE  5
`define USMR_B_PORT_EN     7
`define USMR_B_RX_NINE     6
`define USMR_B_RX_SINGLE   5
`define USMR_B_RX_CONT     4
`define USMR_B_CLK_SRC     7
`define USMR_B_TX_NINE     6
`define USMR_B_TX_EN       5
`define USMR_B_SYNC        4
`define USMR_B_HIGH_SPEED  2
`define USMR_B_TX_NINTH    0

// ==========================================================================
// Reset values
`define USMR_RST_BYTE   8'h00
`define USMR_RST_TRANSMIT_STATUS_CONTROL  8'h02

// ==========================================================================
// Baud prescale in clock cycles per divisor step
`define USMR_PRE_SYNC   8'h04
`define USMR_PRE_ALOW   8'h40
`define USMR_PRE_AHIGH  8'h10

`endif

// ---- rtl/usmr_fifo.v ----
/*
  Two-entry receive buffer holding nine-bit words (data plus ninth bit).
  Assumes push and pop come from logic on the same clock.
*/
`timescale 1ns/1ps
module usmr_fifo
(
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst_n,
  // Fill side
  input  wire       push,
  input  wire [8:0] wdat,
  // Drain side
  input  wire       pop,
  output wire [8:0] head,
  output wire       empty,
  output wire       full
);
  reg  [8:0] mem_r [0:1];
  reg        wp_r;
  reg        rp_r;
  reg  [1:0] cnt_r;
  wire       do_push;
  wire       do_pop;
  genvar     i;

  assign empty   = (cnt_r == 2'h0);
  assign full    = (cnt_r == 2'h2);
  assign head    = mem_r[rp_r];
  assign do_pop  = pop & ~empty;
  assign do_push = push & ~full;

  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_ent
      always @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
          mem_r[i] <= 9'h000;
        else if (do_push && wp_r == i)
          mem_r[i] <= wdat;
    end
  endgenerate

  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      if (do_push)
        wp_r <= ~wp_r;
      if (do_pop)
        rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, do_push} - {1'b0, do_pop};
    end
endmodule

// ---- rtl/usmr_baud.v ----
/*
  Baud generator: one-cycle tick every (divisor + 1) * prescale clocks.
  Assumes divisor and prescale are steady while run is high.
*/
`timescale 1ns/1ps
module usmr_baud
(
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst_n,
  // Control
  input  wire       run,
  input  wire [7:0] divisor,
  input  wire [7:0] prescale,
  // Tick
  output reg        tick_r
);
  reg  [7:0] pre_r;
  reg  [7:0] div_r;
  wire       pre_end;

  assign pre_end = (pre_r == prescale - 8'h01);

  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      pre_r  <= 8'h00;
      div_r  <= 8'h00;
      tick_r <= 1'b0;
    end
    else if (!run)
    begin
      // Restart from zero so each receive starts a full period out
      pre_r  <= 8'h00;
      div_r  <= 8'h00;
      tick_r <= 1'b0;
    end
    else
    begin
      pre_r  <= pre_end ? 8'h00 : pre_r + 8'h01;
      tick_r <= pre_end && (div_r == divisor);
      if (pre_end)
        div_r <= (div_r == divisor) ? 8'h00 : div_r + 8'h01;
    end
endmodule

// ---- tb/usmr_assertions.sv ----
/*
  Port checker for the serial receive block.
  Assumes it is bound to usmr_top and sees only its ports.
*/
`timescale 1ns/1ps
module usmr_assertions
(
  // Clock and reset
  input logic       clk_sys,
  input logic       rst_n,
  // Register port
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic       reg_wr,
  input logic       reg_rd,
  input logic [7:0] reg_rdata_r,
  // Pins and status
  input logic       sck_o_r,
  input logic       sck_oe_r,
  input logic       dat_oe_r,
  input logic       irq_r,
  input logic       tx_enable_r
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ==================================================
  // Register file
  chk_status_fixed: assert property (
    reg_rd && reg_addr == 8'h98 |=> reg_rdata_r[1] && !reg_rdata_r[3])
    else $error("transmit status fixed bits wrong");
  chk_status_store: assert property (
    reg_wr && reg_addr == 8'h98 ##2 reg_rd && reg_addr == 8'h98 |=>
    (reg_rdata_r & 8'hf5) == ($past(reg_wdata, 3) & 8'hf5))
    else $error("transmit status bits not stored");
  chk_tx_disable: assert property (
    reg_wr && reg_addr == 8'h98 && !reg_wdata[5] |-> ##[1:3] !tx_enable_r)
    else $error("transmit enable stayed high");
  chk_rx_override: assert property (
    reg_wr && reg_addr == 8'h18 && reg_wdata[7] && (reg_wdata[5] || reg_wdata[4])
    && sck_oe_r |-> ##[1:3] !tx_enable_r)
    else $error("receive enable did not override transmit");
  chk_irq_mask: assert property (
    reg_wr && reg_addr == 8'h8c && !reg_wdata[5] |-> ##[1:3] !irq_r)
    else $error("interrupt request not masked");

  // ==================================================
  // Serial pins
  chk_clock_mode: assert property (
    reg_wr && reg_addr == 8'h98 && !(reg_wdata[7] && reg_wdata[4]) |-> ##[1:3] !sck_oe_r)
    else $error("clock driven outside synchronous master mode");
  chk_clock_low_time: assert property ($fell(sck_o_r) |=> !sck_o_r [*3])
    else $error("serial clock low phase too short");
  chk_clock_idle: assert property (!sck_oe_r |-> !sck_o_r)
    else $error("serial clock not idle low");
  chk_data_released: assert property (dat_oe_r == 1'b0)
    else $error("data pin driven during reception");
endmodule

bind usmr_top usmr_assertions i_chk
(
  .clk_sys,
  .rst_n,
  .reg_addr,
  .reg_wdata,
  .reg_wr,
  .reg_rd,
  .reg_rdata_r,
  .sck_o_r,
  .sck_oe_r,
  .dat_oe_r,
  .irq_r,
  .tx_enable_r
);

// ---- tb/usmr_peripheral.sv ----
/*
  Synchronous serial peripheral: shifts up to four preloaded words LSB
  first, and in slave tests also makes the serial clock (160 ns).
  Assumes the receiver samples on falling clock edges.
*/
`timescale 1ns/1ps
module usmr_peripheral
(
  // Bench control
  input  logic        load,
  input  logic        make_clk,
  input  logic [35:0] words,
  input  logic [3:0]  nbits,
  // Serial pins
  input  logic        sck,
  output logic        sck_s,
  output logic        dat
);
  int w = 4;
  int b = 0;

  initial
  begin
    sck_s = 1'b0;
    dat = 1'b0;
  end

  // One burst per frame; the clock stands still between frames
  always @(posedge load)
  begin
    w = 0;
    b = 0;
    if (make_clk)
    begin
      repeat (nbits)
      begin
        #80 sck_s = 1'b1;
        #80 sck_s = 1'b0;
      end
    end
  end

  // Change on the rising edge so the bit is steady across the falling one
  always @(posedge sck)
  begin
    if (w < 4)
    begin
      dat = words[w * 9 + b];
      b = b + 1;
      if (b == nbits)
      begin
        b = 0;
        w = w + 1;
      end
    end
    else
      dat = ~dat;
  end
endmodule

// ---- tb/usmr_top_test.sv ----
/*
  Self-checking bench for the serial receive block.
  Assumes usmr_top, the peripheral model and the bound checker.
*/
`timescale 1ns/1ps
module usmr_top_test;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        load = 1'b0;
  logic        make_clk = 1'b0;
  logic [35:0] words = 36'h0;
  logic [3:0]  nbits = 4'h8;
  wire  [7:0]  reg_rdata_r;
  wire         sck_o_r, sck_oe_r, dat_o_r, dat_oe_r, irq_r, tx_enable_r, sck_s, dat_p;
  wire         sck_pin = sck_oe_r ? sck_o_r : sck_s;
  wire         dat_pin = dat_oe_r ? dat_o_r : dat_p;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  usmr_top i_dut
  (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_rdata_r (reg_rdata_r),
    .sck_i       (sck_pin),
    .sck_o_r     (sck_o_r),
    .sck_oe_r    (sck_oe_r),
    .dat_i       (dat_pin),
    .dat_o_r     (dat_o_r),
    .dat_oe_r    (dat_oe_r),
    .irq_r       (irq_r),
    .tx_enable_r (tx_enable_r)
  );

  usmr_peripheral i_peri
  (
    .load     (load),
    .make_clk (make_clk),
    .words    (words),
    .nbits    (nbits),
    .sck      (sck_pin),
    .sck_s    (sck_s),
    .dat      (dat_p)
  );

  always #4 clk_sys = ~clk_sys;

  // The whole run needs about 1300 cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      results();
    end
  end

  // ==================================================
  // Shared tasks
  task automatic results();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata_r);
  endtask

  task automatic frame(input logic [35:0] ws, input logic [3:0] nb);
    words <= ws;
    nbits <= nb;
    @(posedge clk_sys);
    load <= 1'b1;
    @(posedge clk_sys);
    load <= 1'b0;
  endtask

  task automatic falls(input int n);
    repeat (n) @(negedge sck_pin);
    repeat (8) @(posedge clk_sys);
  endtask

  // ==================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] a [8] = '{8'h0b, 8'h0c, 8'h18, 8'h1a, 8'h8c, 8'h98, 8'h99, 8'h40};
    logic [7:0] e [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
    wr(8'h40, 8'hff);
    wr(8'h1a, 8'h55);
    for (int i = 0; i < 8; i++)
      rdchk("reset value", a[i], e[i]);
    $display("test reset done");
  endtask

  task automatic t_transmit_status_control();
    wr(8'h98, 8'hff);
    rdchk("transmit status", 8'h98, 8'hf7);
    wr(8'h99, 8'h01);
    wr(8'h98, 8'h90);
    wr(8'h18, 8'h80);
    repeat (3) @(posedge clk_sys);
    chk("clock drive", 8'h01, {7'h0, sck_oe_r});
    wr(8'h98, 8'h20);
    repeat (3) @(posedge clk_sys);
    chk("async clock drive", 8'h00, {7'h0, sck_oe_r});
    chk("tx enable", 8'h01, {7'h0, tx_enable_r});
    wr(8'h98, 8'hb0);
    $display("test transmit status done");
  endtask

  task automatic t_single();
    frame({27'h0, 9'h0a5}, 4'h8);
    wr(8'h8c, 8'h20);
    wr(8'h0b, 8'hc0);
    wr(8'h18, 8'ha0);
    repeat (3) @(posedge clk_sys);
    chk("tx override", 8'h00, {7'h0, tx_enable_r});
    falls(8);
    chk("irq raised", 8'h01, {7'h0, irq_r});
    rdchk("flag set", 8'h0c, 8'h20);
    repeat (40) @(posedge clk_sys);
    chk("clock stopped", 8'h00, {7'h0, sck_o_r});
    rdchk("single cleared", 8'h18, 8'h80);
    rdchk("word", 8'h1a, 8'ha5);
    rdchk("flag clear", 8'h0c, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk("irq dropped", 8'h00, {7'h0, irq_r});
    wr(8'h8c, 8'h00);
    $display("test single word done");
  endtask

  task automatic t_ninth();
    frame({18'h0, 9'h0c3, 9'h13c}, 4'h9);
    wr(8'h18, 8'hf0);
    falls(18);
    wr(8'h18, 8'h80);
    rdchk("ninth one", 8'h18, 8'h81);
    rdchk("first word", 8'h1a, 8'h3c);
    rdchk("ninth two", 8'h18, 8'h80);
    rdchk("second word", 8'h1a, 8'hc3);
    $display("test ninth bit done");
  endtask

  task automatic t_overrun();
    frame({9'h0, 9'h033, 9'h022, 9'h011}, 4'h8);
    wr(8'h18, 8'h90);
    falls(24);
    rdchk("overrun", 8'h18, 8'h92);
    rdchk("kept one", 8'h1a, 8'h11);
    rdchk("kept two", 8'h1a, 8'h22);
    falls(8);
    rdchk("blocked", 8'h0c, 8'h00);
    wr(8'h18, 8'h80);
    rdchk("overrun cleared", 8'h18, 8'h80);
    $display("test overrun done");
  endtask

  task automatic t_slave();
    wr(8'h98, 8'h10);
    repeat (3) @(posedge clk_sys);
    chk("slave clock drive", 8'h00, {7'h0, sck_oe_r});
    make_clk <= 1'b1;
    wr(8'h18, 8'ha0);
    frame({27'h0, 9'h05a}, 4'h8);
    falls(8);
    rdchk("slave flag", 8'h0c, 8'h20);
    rdchk("slave word", 8'h1a, 8'h5a);
    make_clk <= 1'b0;
    $display("test slave done");
  endtask

  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_transmit_status_control();
    t_single();
    t_ninth();
    t_overrun();
    t_slave();
    results();
  end
endmodule
